/* acc_alu_cfg.svh */
// Purpose: Constants for the accumulator logic and add datapath
// Assumes: 8-bit data, single system clock
// Notes:   Function list below
// Function
// - Add accumulator to memory, write memory, flags
// - AND memory into accumulator, zero only
// - AND immediate into accumulator, zero only
// - AND accumulator into memory byte
`ifndef ACC_ALU_CFG_SVH
`define ACC_ALU_CFG_SVH
// ****************************************
// Reset values
// ****************************************
`define ACC_RESET   8'h00
`define FLAG_RESET  1'b0
`define WDATA_RESET 8'h00
// ****************************************
// Operation codes
// ****************************************
`define OP_ADDM     2'h0
`define OP_ANDA     2'h1
`define OP_ANDI     2'h2
`define OP_AND_TO_MEM 2'h3
`endif

/* acc_alu_pkg.sv */
// Purpose: Types for the accumulator logic and add datapath
// Assumes: Constants come from acc_alu_cfg.svh
// Notes:   State held as one packed struct
package acc_alu_pkg;
  typedef logic [7:0] byte_t;
  // Whole registered state of the datapath
  typedef struct packed {
    byte_t accumulator_reg;
    byte_t mem_wdata;
    logic  mem_we;
    logic  overflow_flag;
    logic  zero_flag;
    logic  aux_carry_flag;
    logic  carry_flag;
    logic  done;
  } alu_state_s;
endpackage

/* acc_alu.sv */
// Purpose: Add-to-memory and three AND operations on the accumulator
// Assumes: Sequencer presents operands with a one-cycle op_valid pulse
// Notes:   Results and flags appear one cycle after op_valid
`timescale 1ns/1ns
`include "acc_alu_cfg.svh"
module acc_alu
  import acc_alu_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Operation request from the sequencer
  input  wire logic       op_valid,
  input  wire logic [1:0] op_code,
  input  wire logic [7:0] mem_rdata,
  input  wire logic [7:0] imm_data,
  // Data memory write-back
  output logic      [7:0] mem_wdata,
  output logic            mem_we,
  // Accumulator and status flags
  output logic      [7:0] accumulator_reg,
  output logic            overflow_flag,
  output logic            zero_flag,
  output logic            aux_carry_flag,
  output logic            carry_flag,
  output logic            op_done
);

  // ****************************************
  // State
  // ****************************************
  alu_state_s st;       // Registered state
  alu_state_s next_st;  // Next state
  logic [8:0] sum9;     // Full sum with carry out
  logic [4:0] sum5;     // Low nibble sum for aux carry
  logic [7:0] sum7;     // Low seven bits for overflow
  logic [7:0] and_m;    // Accumulator AND memory
  logic [7:0] and_i;    // Accumulator AND immediate

  // Arithmetic terms first, then the next state; write strobe and
  // done are single-cycle pulses
  always_comb begin
    sum9  = {1'b0, st.accumulator_reg} + {1'b0, mem_rdata};
    sum5  = {1'b0, st.accumulator_reg[3:0]} + {1'b0, mem_rdata[3:0]};
    sum7  = {1'b0, st.accumulator_reg[6:0]} + {1'b0, mem_rdata[6:0]};
    and_m = st.accumulator_reg & mem_rdata;
    and_i = st.accumulator_reg & imm_data;
    next_st        = st;
    next_st.mem_we = 1'b0;
    next_st.done   = 1'b0;
    if (op_valid) begin
      next_st.done = 1'b1;
      case (op_code)
        `OP_ADDM: begin
          // Sum to memory, zero and all three arithmetic flags
          next_st.mem_wdata      = sum9[7:0];
          next_st.mem_we         = 1'b1;
          next_st.carry_flag     = sum9[8];
          next_st.aux_carry_flag = sum5[4];
          next_st.overflow_flag  = sum9[8] ^ sum7[7];
          next_st.zero_flag      = (sum9[7:0] == 8'h00);
        end
        `OP_ANDA: begin
          // Memory operand into accumulator, zero only
          next_st.accumulator_reg = and_m;
          next_st.zero_flag       = (and_m == 8'h00);
        end
        `OP_ANDI: begin
          // Immediate operand into accumulator
          next_st.accumulator_reg = and_i;
          next_st.zero_flag       = (and_i == 8'h00);
        end
        `OP_AND_TO_MEM: begin
          // Result goes to memory; accumulator kept. Flags are kept
          // too, so only the memory byte changes.
          next_st.mem_wdata = and_m;
          next_st.mem_we    = 1'b1;
        end
        default: begin
          next_st.done = 1'b0;
        end
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{accumulator_reg: `ACC_RESET, mem_wdata: `WDATA_RESET,
              mem_we: 1'b0, overflow_flag: `FLAG_RESET,
              zero_flag: `FLAG_RESET, aux_carry_flag: `FLAG_RESET,
              carry_flag: `FLAG_RESET, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign mem_wdata       = st.mem_wdata;
  assign mem_we          = st.mem_we;
  assign accumulator_reg = st.accumulator_reg;
  assign overflow_flag   = st.overflow_flag;
  assign zero_flag       = st.zero_flag;
  assign aux_carry_flag  = st.aux_carry_flag;
  assign carry_flag      = st.carry_flag;
  assign op_done         = st.done;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_add;
    op_valid && op_code == `OP_ADDM;
  endsequence

  // One request of each AND kind, as seen on the taking edge
  sequence s_anda;
    op_valid && op_code == `OP_ANDA;
  endsequence

  sequence s_andi;
    op_valid && op_code == `OP_ANDI;
  endsequence

  sequence s_and_to_mem;
    op_valid && op_code == `OP_AND_TO_MEM;
  endsequence

  // Carry, aux carry and overflow all held over the result cycle
  sequence s_flags_kept;
    $stable(carry_flag) && $stable(aux_carry_flag)
      && $stable(overflow_flag);
  endsequence

  property p_add_mem;
    @(posedge clk_sys) disable iff (srst)
      s_add |=> mem_we && mem_wdata ==
        8'($past(accumulator_reg) + $past(mem_rdata));
  endproperty
  a_add_mem: assert property (p_add_mem)
    else $error("add result not written to memory");

  property p_add_carry;
    @(posedge clk_sys) disable iff (srst)
      s_add |=> carry_flag ==
        ((9'($past(accumulator_reg)) + 9'($past(mem_rdata))) > 9'h0ff);
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("carry wrong after add");

  property p_anda;
    @(posedge clk_sys) disable iff (srst)
      op_valid && op_code == `OP_ANDA |=> !mem_we &&
        accumulator_reg == ($past(accumulator_reg) & $past(mem_rdata))
        && $stable(carry_flag);
  endproperty
  a_anda: assert property (p_anda)
    else $error("memory AND into accumulator wrong");

  property p_andi;
    @(posedge clk_sys) disable iff (srst)
      op_valid && op_code == `OP_ANDI |=> !mem_we &&
        accumulator_reg == ($past(accumulator_reg) & $past(imm_data))
        && $stable(overflow_flag);
  endproperty
  a_andi: assert property (p_andi)
    else $error("immediate AND into accumulator wrong");

  property p_and_to_mem;
    @(posedge clk_sys) disable iff (srst)
      s_and_to_mem |=> mem_we && $stable(accumulator_reg)
        && mem_wdata == ($past(accumulator_reg) & $past(mem_rdata));
  endproperty
  a_and_to_mem: assert property (p_and_to_mem)
    else $error("AND to memory wrong");

  property p_zero;
    @(posedge clk_sys) disable iff (srst)
      op_valid && op_code == `OP_ANDA |=>
        zero_flag == (accumulator_reg == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  // Aux carry is the carry out of the low nibble
  property p_add_aux;
    @(posedge clk_sys) disable iff (srst)
      s_add |=> aux_carry_flag ==
        ((5'($past(accumulator_reg[3:0])) + 5'($past(mem_rdata[3:0])))
          > 5'h0f);
  endproperty
  a_add_aux: assert property (p_add_aux)
    else $error("aux carry wrong after add");

  // Signed overflow: like signs in, the other sign out
  property p_add_ovf;
    @(posedge clk_sys) disable iff (srst)
      s_add |=> overflow_flag ==
        (($past(accumulator_reg[7]) == $past(mem_rdata[7])) &&
         (mem_wdata[7] != $past(accumulator_reg[7])));
  endproperty
  a_add_ovf: assert property (p_add_ovf)
    else $error("overflow wrong after add");

  // Zero follows the byte written back by an add
  property p_add_zero;
    @(posedge clk_sys) disable iff (srst)
      s_add |=> zero_flag == (mem_wdata == 8'h00);
  endproperty
  a_add_zero: assert property (p_add_zero)
    else $error("zero flag wrong after add");

  // Memory AND touches no arithmetic flag
  property p_anda_flags;
    @(posedge clk_sys) disable iff (srst)
      s_anda |=> s_flags_kept;
  endproperty
  a_anda_flags: assert property (p_anda_flags)
    else $error("memory AND changed an arithmetic flag");

  // Immediate AND touches no arithmetic flag
  property p_andi_flags;
    @(posedge clk_sys) disable iff (srst)
      s_andi |=> s_flags_kept;
  endproperty
  a_andi_flags: assert property (p_andi_flags)
    else $error("immediate AND changed an arithmetic flag");

  // Zero follows the accumulator after an immediate AND
  property p_andi_zero;
    @(posedge clk_sys) disable iff (srst)
      s_andi |=> zero_flag == (accumulator_reg == 8'h00);
  endproperty
  a_andi_zero: assert property (p_andi_zero)
    else $error("zero flag wrong after immediate AND");

  // AND to memory keeps every arithmetic flag
  property p_and_to_mem_flags;
    @(posedge clk_sys) disable iff (srst)
      s_and_to_mem |=> s_flags_kept;
  endproperty
  a_and_to_mem_flags: assert property (p_and_to_mem_flags)
    else $error("AND to memory changed an arithmetic flag");

  property p_and_to_mem_zero;
    @(posedge clk_sys) disable iff (srst)
      s_and_to_mem |=> $stable(zero_flag);
  endproperty
  a_and_to_mem_zero: assert property (p_and_to_mem_zero)
    else $error("AND to memory changed the zero flag");

  // No request, no change; the reset edge is left out, since reset
  // itself may clear the accumulator and flags
  property p_idle;
    @(posedge clk_sys) disable iff (srst)
      !op_valid && !srst |=> !mem_we && !op_done
        && $stable(accumulator_reg) && $stable(zero_flag);
  endproperty
  a_idle: assert property (p_idle)
    else $error("state changed without a request");

endmodule

/* mem_model.sv */
// Purpose: Data memory seen by the datapath
// Assumes: Write-back lands at the address of its request
// Notes:   Four bytes, no wait states
`timescale 1ns/1ns
module mem_model (
  // Clock and access
  input  wire logic       clk_sys,
  input  wire logic       op_valid,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       we,
  // Read side
  output logic      [7:0] rdata
);
  logic [7:0] mem [4];  // Storage
  logic [1:0] wr_addr;  // Held, since the write comes a cycle late
  assign rdata = mem[addr];
  // Fixed contents; the sum needs no carry, acc stays zero
  initial begin
    mem = '{8'h81, 8'h7f, 8'h00, 8'h3c};
  end
  // Capture address, then take the write-back
  always @(posedge clk_sys) begin
    if (op_valid) wr_addr <= addr;
    if (we) mem[wr_addr] <= wdata;
  end
endmodule

/* accumulator_logic_add_ops_tb_top.sv */
// Purpose: Self-checking bench for the accumulator datapath
// Assumes: Results land one cycle after op_valid
// Notes:   No load port, so the accumulator stays zero
`timescale 1ns/1ns
`include "acc_alu_cfg.svh"
module accumulator_logic_add_ops_tb_top import acc_alu_pkg::*;;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       op_valid = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic [1:0] addr = 2'h0;
  byte_t      imm_data = 8'h00;
  byte_t      mem_rdata, mem_wdata, acc;
  logic       mem_we, overflow_flag, zero_flag, aux_carry_flag;
  logic       carry_flag, op_done;
  int         bad_count = 0;
  int         checked = 0;
  int         cycles = 0;
  always #20 clk_sys = ~clk_sys;
  acc_alu acc_alu_i (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid),
    .op_code(op_code), .mem_rdata(mem_rdata), .imm_data(imm_data),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .accumulator_reg(acc),
    .overflow_flag(overflow_flag), .zero_flag(zero_flag),
    .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag),
    .op_done(op_done));
  mem_model mem_model_i (.clk_sys(clk_sys), .op_valid(op_valid),
    .addr(addr), .wdata(mem_wdata), .we(mem_we), .rdata(mem_rdata));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input byte_t got, input byte_t exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, judged on the cycle after it is taken
  task automatic op(input logic [1:0] code, input logic [1:0] a,
    input byte_t imm, input logic we, input byte_t wd, input logic zf);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code  <= code;
    addr     <= a;
    imm_data <= imm;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    check({7'h00, op_done}, 8'h01);
    check({7'h00, mem_we}, {7'h00, we});
    if (we) check(mem_wdata, wd);
    check({7'h00, zero_flag}, {7'h00, zf});
    check({5'h00, overflow_flag, aux_carry_flag, carry_flag}, 8'h00);
    check(acc, 8'h00);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Sum written back; zero result raises the zero flag
  task automatic t_add();
    op(`OP_ADDM, 2'h0, 8'h00, 1'b1, 8'h81, 1'b0);
    op(`OP_ADDM, 2'h2, 8'h00, 1'b1, 8'h00, 1'b1);
  endtask
  // Zero flag cleared first so the AND must set it
  task automatic t_and_mem();
    op(`OP_ADDM, 2'h0, 8'h00, 1'b1, 8'h81, 1'b0);
    op(`OP_ANDA, 2'h1, 8'h00, 1'b0, 8'h00, 1'b1);
  endtask
  task automatic t_and_imm();
    op(`OP_ADDM, 2'h0, 8'h00, 1'b1, 8'h81, 1'b0);
    op(`OP_ANDI, 2'h0, 8'hff, 1'b0, 8'h00, 1'b1);
  endtask
  // Reset in mid-run clears held write data and the zero flag
  task automatic t_reset();
    op(`OP_ADDM, 2'h0, 8'h00, 1'b1, 8'h81, 1'b0);
    op(`OP_ANDI, 2'h0, 8'h00, 1'b0, 8'h00, 1'b1);
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check(mem_wdata, 8'h00);
    check({6'h00, op_done, zero_flag}, 8'h00);
  endtask
  // Zero cleared first, so a kept flag reads zero; the result must
  // reach memory, as a later add reads it back
  task automatic t_and_to_mem();
    op(`OP_ADDM, 2'h0, 8'h00, 1'b1, 8'h81, 1'b0);
    op(`OP_AND_TO_MEM, 2'h3, 8'h00, 1'b1, 8'h00, 1'b0);
    op(`OP_ADDM, 2'h3, 8'h00, 1'b1, 8'h00, 1'b1);
  endtask
  // Hang guard, far above the few dozen cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 400) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check({mem_we, op_done, zero_flag, overflow_flag, aux_carry_flag,
      carry_flag, 2'h0}, 8'h00);
    check(acc, 8'h00);
    check(mem_wdata, 8'h00);
    t_add();
    t_and_mem();
    t_and_imm();
    t_reset();
    t_and_to_mem();
    end_of_test();
  end
endmodule
